/* File: core/tsspi_pkg.sv */
package tsspi_pkg;
    // clock and internal sample rate
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned SAMPLE_RATE_HZ = 1000;
    localparam int unsigned SAMPLE_DIV_DEF = CLK_HZ / SAMPLE_RATE_HZ;

    // frame layout
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam int CMD_HI = 15;
    localparam int CMD_LO = 14;
    localparam int ADDR_HI = 13;
    localparam int ADDR_LO = 8;
    localparam int DATA_HI = 7;

    // output data word layout
    localparam int NEW_BIT = 15;
    localparam int ALARM_BIT = 14;
    localparam int DATA_W = 14;
    localparam int NARROW_W = 12;
    localparam logic [15:0] OUT_RESET = 16'h0000;

    // output data registers, lower byte address of each pair
    localparam int NUM_OUT_REGS = 5;
    localparam logic [5:0] ADDR_SUPPLY_VOLTAGE_SAMPLE = 6'h02;
    localparam logic [5:0] ADDR_AUXILIARY_INPUT_SAMPLE = 6'h08;
    localparam logic [5:0] ADDR_TEMPERATURE_SAMPLE = 6'h0a;
    localparam logic [5:0] ADDR_TILT_ANGLE_FULL_TURN = 6'h0c;
    localparam logic [5:0] ADDR_TILT_ANGLE_SIGNED = 6'h0e;

    // index of each register in the bank
    localparam logic [2:0] IDX_SUPPLY = 3'h0;
    localparam logic [2:0] IDX_AUX = 3'h1;
    localparam logic [2:0] IDX_TEMP = 3'h2;
    localparam logic [2:0] IDX_FULL = 3'h3;
    localparam logic [2:0] IDX_SIGNED = 3'h4;
endpackage

/* File: core/tsspi_reg_if.sv */
`timescale 1ns/100ps
`default_nettype none
// one output data register as seen from the port logic
interface tsspi_reg_if;
    logic ld;
    logic clr;
    logic alarm;
    logic [13:0] meas;
    logic [15:0] word;
    modport ctrl (output ld, output clr, output alarm, output meas, input word);
    modport store (input ld, input clr, input alarm, input meas, output word);
endinterface
`default_nettype wire

/* File: core/tsspi_outreg.sv */
`timescale 1ns/100ps
`default_nettype none
module tsspi_outreg
    import tsspi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    tsspi_reg_if.store rif
);
    logic [15:0] word_q;
    logic [15:0] word_d;

    // fresh sample sets the flag; a load in the clearing cycle wins
    always_comb begin
        word_d = word_q;
        if (rif.clr) begin
            word_d[NEW_BIT] = 1'b0;
        end
        if (rif.ld) begin
            word_d[DATA_W-1:0] = rif.meas;
            word_d[NEW_BIT] = 1'b1;
        end
        word_d[ALARM_BIT] = rif.alarm;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_q <= OUT_RESET;
        end else begin
            word_q <= word_d;
        end
    end

    assign rif.word = word_q;

    a_load_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
        rif.ld |=> word_q[NEW_BIT] && word_q[DATA_W-1:0] == $past(rif.meas))
        else $error("new data flag or value missing after load");
    a_read_clears_flag: assert property (@(posedge clk) disable iff (!rst_n)
        rif.clr && !rif.ld |=> !word_q[NEW_BIT] until rif.ld)
        else $error("new data flag came back without a load");
    a_alarm_follows: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 word_q[ALARM_BIT] == $past(rif.alarm))
        else $error("alarm flag does not follow alarm condition");
endmodule
`default_nettype wire

/* File: core/tsspi_port.sv */
// Summary of operation
// - chip select high: output floats, clock and data input ignored
// - a frame is at least sixteen serial clocks under chip select low; clocks past sixteen are ignored
// - full duplex: sixteen bits in and sixteen bits out every frame
// - a write touches only the addressed byte; full word needs two frames
// - either byte address of a register reads the whole sixteen bits
// - read data comes out in the frame after the command
// - reads pipeline: N back-to-back reads take N plus one frames
// - each register has two bytes, each with its own six-bit address
// - output registers refresh at the sample rate regardless of reads
// - bit 15 new-data flag set whenever register gets a fresh sample
// - reading a register clears its new-data flag until next update
// - bit 14 alarm flag is set while an alarm condition is active
// - data is 12 or 14 low bits; bits 13:12 unused in 12-bit ones
// - supply at 0x02/03, auxiliary input 0x08/09, temperature 0x0a/0b
// - 14-bit angles: full turn at 0x0c/0d, signed half turn at 0x0e/0f
// - first output bit appears when chip select falls
// - later output bits change after serial clock falling edges
// - data input sampled on serial clock rising edges
`timescale 1ns/100ps
`default_nettype none
module tsspi_port
    import tsspi_pkg::*;
#(
    parameter int unsigned SAMPLE_DIV = SAMPLE_DIV_DEF
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic SPI_CS_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_DIN,
    output logic SPI_DOUT,
    output logic SPI_DOUT_OE_N,
    input wire logic [11:0] SUPPLY_MEAS,
    input wire logic [11:0] AUX_MEAS,
    input wire logic [11:0] TEMP_MEAS,
    input wire logic [13:0] ANGLE_FULL_MEAS,
    input wire logic [13:0] ANGLE_SIGNED_MEAS,
    input wire logic ALARM_ACTIVE,
    output logic WR_STB,
    output logic [5:0] WR_ADDR,
    output logic [7:0] WR_DATA
);
    // pin synchronisers; first stage feeds only the second
    logic cs_m_q, cs_s_q, cs_d_q;
    logic sclk_m_q, sclk_s_q, sclk_d_q;
    logic din_m_q, din_s_q;
    logic alarm_m_q, alarm_s_q;

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_d_q <= 1'b1;
            sclk_m_q <= 1'b1;
            sclk_s_q <= 1'b1;
            sclk_d_q <= 1'b1;
            din_m_q <= 1'b0;
            din_s_q <= 1'b0;
            alarm_m_q <= 1'b0;
            alarm_s_q <= 1'b0;
        end else begin
            cs_m_q <= SPI_CS_N;
            cs_s_q <= cs_m_q;
            cs_d_q <= cs_s_q;
            sclk_m_q <= SPI_SCLK;
            sclk_s_q <= sclk_m_q;
            sclk_d_q <= sclk_s_q;
            din_m_q <= SPI_DIN;
            din_s_q <= din_m_q;
            alarm_m_q <= ALARM_ACTIVE;
            alarm_s_q <= alarm_m_q;
        end
    end

    // serial clock edges seen only inside a frame
    logic cs_fall, cs_rise, sclk_rise, sclk_fall, in_frame;
    assign in_frame = !cs_s_q;
    assign cs_fall = !cs_s_q && cs_d_q;
    assign cs_rise = cs_s_q && !cs_d_q;
    assign sclk_rise = sclk_s_q && !sclk_d_q && in_frame;
    assign sclk_fall = !sclk_s_q && sclk_d_q && in_frame;

    // sample-rate divider
    logic [31:0] div_q, div_d;
    logic smpl_en;
    assign smpl_en = (div_q == SAMPLE_DIV - 32'd1);

    always_comb begin
        div_d = smpl_en ? 32'd0 : div_q + 32'd1;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            div_q <= 32'd0;
        end else begin
            div_q <= div_d;
        end
    end

    // output data register bank
    tsspi_reg_if rif [NUM_OUT_REGS] ();
    logic [15:0] words [NUM_OUT_REGS];
    logic [NUM_OUT_REGS-1:0] clr_q, clr_d;

    assign rif[IDX_SUPPLY].meas = {2'b00, SUPPLY_MEAS};
    assign rif[IDX_AUX].meas = {2'b00, AUX_MEAS};
    assign rif[IDX_TEMP].meas = {2'b00, TEMP_MEAS};
    assign rif[IDX_FULL].meas = ANGLE_FULL_MEAS;
    assign rif[IDX_SIGNED].meas = ANGLE_SIGNED_MEAS;

    // every register reloads on the sample tick, reads or not
    for (genvar i = 0; i < NUM_OUT_REGS; i++) begin : g_reg
        assign rif[i].ld = smpl_en;
        assign rif[i].clr = clr_q[i];
        assign rif[i].alarm = alarm_s_q;
        assign words[i] = rif[i].word;
        tsspi_outreg u_reg (
            .clk(REF_CLK),
            .rst_n(RESETN),
            .rif(rif[i])
        );
    end

    // frame state
    logic [15:0] rx_q, rx_d;
    logic [15:0] tx_q, tx_d;
    logic [4:0] cnt_q, cnt_d;
    logic dout_q, dout_d;
    logic oe_n_q, oe_n_d;
    logic rd_pend_q, rd_pend_d;
    logic [2:0] rd_idx_q, rd_idx_d;
    logic wr_stb_q, wr_stb_d;
    logic [5:0] wr_addr_q, wr_addr_d;
    logic [7:0] wr_data_q, wr_data_d;
    logic [15:0] resp;
    logic [5:0] cmd_addr;
    logic hit;
    logic [2:0] hit_idx;

    // pending read result; nothing pending shifts out zeros
    assign resp = rd_pend_q ? words[rd_idx_q] : 16'h0000;
    assign cmd_addr = rx_q[ADDR_HI:ADDR_LO];

    // both byte addresses of a pair map to one register
    always_comb begin
        hit = 1'b1;
        hit_idx = IDX_SUPPLY;
        if (cmd_addr[5:1] == ADDR_SUPPLY_VOLTAGE_SAMPLE[5:1]) begin
            hit_idx = IDX_SUPPLY;
        end else if (cmd_addr[5:1] == ADDR_AUXILIARY_INPUT_SAMPLE[5:1]) begin
            hit_idx = IDX_AUX;
        end else if (cmd_addr[5:1] == ADDR_TEMPERATURE_SAMPLE[5:1]) begin
            hit_idx = IDX_TEMP;
        end else if (cmd_addr[5:1] == ADDR_TILT_ANGLE_FULL_TURN[5:1]) begin
            hit_idx = IDX_FULL;
        end else if (cmd_addr[5:1] == ADDR_TILT_ANGLE_SIGNED[5:1]) begin
            hit_idx = IDX_SIGNED;
        end else begin
            hit = 1'b0;
        end
    end

    // shifter, command decode and read pipeline
    always_comb begin
        rx_d = rx_q;
        tx_d = tx_q;
        cnt_d = cnt_q;
        dout_d = dout_q;
        oe_n_d = cs_s_q;
        rd_pend_d = rd_pend_q;
        rd_idx_d = rd_idx_q;
        wr_stb_d = 1'b0;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        clr_d = '0;
        if (cs_fall) begin
            // msb goes out at chip select, not at a clock edge
            tx_d = resp;
            dout_d = resp[15];
            cnt_d = 5'h00;
            if (rd_pend_q) begin
                clr_d[rd_idx_q] = 1'b1;
            end
            rd_pend_d = 1'b0;
        end else if (cs_rise) begin
            // frames of fewer than sixteen clocks are dropped whole
            if (cnt_q == FRAME_BITS) begin
                if (rx_q[CMD_HI:CMD_LO] == CMD_WRITE) begin
                    wr_stb_d = 1'b1;
                    wr_addr_d = cmd_addr;
                    wr_data_d = rx_q[DATA_HI:0];
                end else if (rx_q[CMD_HI:CMD_LO] == CMD_READ && hit) begin
                    rd_pend_d = 1'b1;
                    rd_idx_d = hit_idx;
                end
            end
        end else begin
            if (sclk_rise && cnt_q != FRAME_BITS) begin
                rx_d = {rx_q[14:0], din_s_q};
                cnt_d = cnt_q + 5'h01;
            end
            if (sclk_fall && cnt_q != 5'h00) begin
                tx_d = {tx_q[14:0], 1'b0};
                dout_d = tx_q[14];
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            rx_q <= 16'h0000;
            tx_q <= 16'h0000;
            cnt_q <= 5'h00;
            dout_q <= 1'b0;
            oe_n_q <= 1'b1;
            rd_pend_q <= 1'b0;
            rd_idx_q <= 3'h0;
            wr_stb_q <= 1'b0;
            wr_addr_q <= 6'h00;
            wr_data_q <= 8'h00;
            clr_q <= '0;
        end else begin
            rx_q <= rx_d;
            tx_q <= tx_d;
            cnt_q <= cnt_d;
            dout_q <= dout_d;
            oe_n_q <= oe_n_d;
            rd_pend_q <= rd_pend_d;
            rd_idx_q <= rd_idx_d;
            wr_stb_q <= wr_stb_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            clr_q <= clr_d;
        end
    end

    assign SPI_DOUT = dout_q;
    assign SPI_DOUT_OE_N = oe_n_q;
    assign WR_STB = wr_stb_q;
    assign WR_ADDR = wr_addr_q;
    assign WR_DATA = wr_data_q;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    a_idle_float: assert property (cs_s_q |=> oe_n_q)
        else $error("data output driven while deselected");
    a_idle_ignore: assert property (cs_s_q && !cs_rise |=> $stable(cnt_q) && $stable(rx_q))
        else $error("shifter moved while deselected");
    a_frame_len: assert property (cnt_q <= FRAME_BITS)
        else $error("more than sixteen bits counted");
    a_write_decode: assert property (wr_stb_q |-> $past(rx_q[CMD_HI:CMD_LO]) == CMD_WRITE
        && wr_data_q == $past(rx_q[DATA_HI:0]) && $past(cnt_q) == FRAME_BITS)
        else $error("write strobe without a full write frame");
    a_read_next_frame: assert property (cs_fall && rd_pend_q |=> tx_q == $past(words[rd_idx_q])
        && clr_q[$past(rd_idx_q)])
        else $error("read data not loaded at next frame");
    a_msb_at_select: assert property (cs_fall |=> dout_q == $past(resp[15]))
        else $error("first bit not presented at chip select");
    a_shift_on_fall: assert property (sclk_fall && cnt_q != 5'h00 && !cs_fall && !cs_rise
        |=> dout_q == $past(tx_q[14]))
        else $error("output bit not advanced on falling clock");
    a_sample_on_rise: assert property (sclk_rise && cnt_q != FRAME_BITS && !cs_fall && !cs_rise
        |=> rx_q[0] == $past(din_s_q) && cnt_q == $past(cnt_q) + 5'h01)
        else $error("input bit not taken on rising clock");
endmodule
`default_nettype wire

/* File: tb/tsspi_host.sv */
`timescale 1ns/100ps
`default_nettype none
// spi master model, mode 3, four ref clocks per sclk half period
module tsspi_host (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic oe_n
);
    // sclk stands still high outside frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // nbits clocks, msb first both ways; sel low keeps chip select high
    task automatic frame(input logic [15:0] tx, input int nbits, input logic sel,
                         output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clk);
        cs_n = ~sel;
        wait_clk(4);
        for (int i = 0; i < nbits; i++) begin
            sclk = 1'b0;
            din = tx[15 - i]; // moves at the fall, far from the sampling rise
            wait_clk(4);
            sclk = 1'b1;
            rx = {rx[14:0], (oe_n === 1'b0) ? dout : 1'bx}; // floating output reads as unknown
            wait_clk(4);
        end
        cs_n = 1'b1;
        din = ~din; // released line shows the inverse of its last bit
        wait_clk(6);
    endtask
endmodule
`default_nettype wire

/* File: tb/tilt_sensor_spi_output_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tilt_sensor_spi_output_port_tb;
    import tsspi_pkg::*;
    localparam int unsigned SDIV = 1500;
    localparam int LIMIT = 6000;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cs_n, sclk, din, dout, oe_n, wr_stb;
    logic [11:0] supply = 12'habc;
    logic alarm = 1'b1;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic [15:0] rx;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int wr_count = 0;
    // read commands mixing even and odd addresses, then one write
    logic [15:0] cmds [7] = '{16'h0200, 16'h0300, 16'h0800, 16'h0bff, 16'h0c00, 16'h0fff,
                              16'hbea5};
    logic [15:0] exps [7] = '{16'h0000, 16'hcabc, 16'h4abc, 16'hc123, 16'hc456, 16'hda94,
                              16'hf176};

    always #20 ref_clk = ~ref_clk;

    tsspi_host u_host (.clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
                       .oe_n(oe_n));

    tsspi_port #(.SAMPLE_DIV(SDIV)) u_dut (.REF_CLK(ref_clk), .RESETN(resetn),
        .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_DIN(din), .SPI_DOUT(dout),
        .SPI_DOUT_OE_N(oe_n), .SUPPLY_MEAS(supply), .AUX_MEAS(12'h123),
        .TEMP_MEAS(12'h456), .ANGLE_FULL_MEAS(14'h1a94), .ANGLE_SIGNED_MEAS(14'h3176),
        .ALARM_ACTIVE(alarm), .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // write pulses and cycle count; the ceiling cuts a hang short
    always @(posedge ref_clk) begin
        cyc++;
        if (wr_stb === 1'b1) begin
            wr_count++;
        end
        if (cyc == LIMIT) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        check({oe_n, wr_stb, wr_addr, wr_data}, 16'h8000);
        // clocks and a write pattern with chip select high must do nothing
        u_host.frame(16'hbea5, 16, 1'b0, rx);
        check(16'(wr_count), 16'h0000);
        $display("test idle done");
        // past the first sample tick, then pipelined reads ending in a write
        while (cyc < SDIV + 16) @(negedge ref_clk);
        for (int i = 0; i < 7; i++) begin
            u_host.frame(cmds[i], 16, 1'b1, rx);
            if (i > 0) begin
                check(rx, exps[i]);
            end
        end
        check({2'b00, wr_addr, wr_data}, 16'h3ea5);
        check(16'(wr_count), 16'h0001);
        $display("test pipeline done");
        // a fifteen clock write frame is refused
        u_host.frame(16'h8211, 15, 1'b1, rx);
        check(16'(wr_count), 16'h0001);
        $display("test short frame done");
        // new sample after the second tick, alarm gone, unmapped read gives zero
        supply = 12'h789;
        alarm = 1'b0;
        while (cyc < 2 * SDIV + 16) @(negedge ref_clk);
        u_host.frame(16'h3e00, 16, 1'b1, rx);
        u_host.frame(16'h0300, 16, 1'b1, rx);
        check(rx, 16'h0000);
        u_host.frame(16'h0000, 16, 1'b1, rx);
        check(rx, 16'h8789);
        $display("test refresh done");
        wrap_up();
    end
endmodule
`default_nettype wire
